/* File: pkg/baud_pkg.sv */
// Purpose: shared constants and types of the baud rate timer
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes:   register offsets are byte addresses
package baud_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_TX_CTRL  = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_RX_CTRL  = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_BAUD_CTL = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_DIV_LO   = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_DIV_HI   = 5'h10;

    // field positions
    localparam int POS_SYNC      = 4;
    localparam int POS_HIGH_SPD  = 2;
    localparam int POS_WIDE      = 3;
    localparam int POS_RX_IDLE   = 6;
    localparam int POS_TX_EMPTY  = 1;
    localparam int POS_PORT_EN   = 7;

    // writable masks of the three control registers
    localparam logic [7:0] TX_CTRL_WMASK  = 8'hFD;
    localparam logic [7:0] RX_CTRL_WMASK  = 8'hF8;
    localparam logic [7:0] BAUD_CTL_WMASK = 8'h1B;

    // reset values
    localparam logic [7:0] TX_CTRL_RST  = 8'h00;
    localparam logic [7:0] RX_CTRL_RST  = 8'h00;
    localparam logic [7:0] BAUD_CTL_RST = 8'h00;
    localparam logic [7:0] DIV_RST      = 8'h00;

    // prescale ratios
    localparam logic [5:0] PRE_64 = 6'h3F;
    localparam logic [5:0] PRE_16 = 6'h0F;
    localparam logic [5:0] PRE_4  = 6'h03;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       sync_mode;
        logic       high_speed_select;
        logic       wide_divisor_select;
        logic [15:0] divisor;
    } baud_cfg_s;

    typedef struct packed {
        logic            we;
        logic [ADDR_W-1:0] addr;
        logic [7:0]      data;
    } reg_wr_s;

endpackage

/* File: hdl/baud_axil_slave.sv */
// Purpose: AXI4-Lite slave front end; turns bus traffic into register strobes
// Assumes: one write and one read under way at a time
// Notes:   unmapped addresses answer SLVERR, reads return zero
`timescale 1ns/1ps
module baud_axil_slave (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // write channels
    input  wire logic [baud_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [baud_pkg::DATA_W-1:0]   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    // read channels
    input  wire logic [baud_pkg::ADDR_W-1:0]   araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [baud_pkg::DATA_W-1:0]        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // register side
    output baud_pkg::reg_wr_s                  reg_wr,
    output logic [baud_pkg::ADDR_W-1:0]        rd_addr,
    input  wire logic [7:0]                    rd_data,
    input  wire logic                          rd_hit
);
    import baud_pkg::*;

    logic              aw_held_reg;
    logic              w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0]        w_data_reg;
    logic              w_lane0_reg;
    logic              wr_go;

    assign awready = !aw_held_reg && !bvalid;
    assign wready  = !w_held_reg && !bvalid;
    assign wr_go   = aw_held_reg && w_held_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (awvalid && awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else if (wr_go) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            w_held_reg  <= 1'b0;
            w_data_reg  <= '0;
            w_lane0_reg <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_reg  <= 1'b1;
            w_data_reg  <= wdata[7:0];
            w_lane0_reg <= wstrb[0];
        end else if (wr_go) begin
            w_held_reg <= 1'b0;
        end
    end

    // write strobe lasts one cycle, only for lane 0 of a mapped word
    assign reg_wr.we   = wr_go && w_lane0_reg && rd_hit_w(aw_addr_reg);
    assign reg_wr.addr = aw_addr_reg;
    assign reg_wr.data = w_data_reg;

    function automatic logic rd_hit_w(input logic [ADDR_W-1:0] a);
        rd_hit_w = (a == OFF_TX_CTRL) || (a == OFF_RX_CTRL) || (a == OFF_BAUD_CTL)
                || (a == OFF_DIV_LO) || (a == OFF_DIV_HI);
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= rd_hit_w(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    assign arready = !rvalid;
    assign rd_addr = araddr;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {24'h000000, rd_hit ? rd_data : 8'h00};
            rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

/* File: hdl/baud_timer.sv */
// Purpose: prescaler and reload counter producing the baud tick
// Assumes: configuration is stable between writes
// Notes:   restart clears prescaler and reloads counter at once
`timescale 1ns/1ps
module baud_timer (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // control
    input  wire baud_pkg::baud_cfg_s  cfg,
    input  wire logic                 restart,
    input  wire logic                 run,
    // status
    output logic                      baud_tick,
    output logic [15:0]               count
);
    import baud_pkg::*;

    logic [5:0]  pre_reg;
    logic [5:0]  pre_last;
    logic [15:0] cnt_reg;
    logic [15:0] reload;
    logic        pre_done;

    // multiplier choice; high speed is ignored in synchronous mode
    always_comb begin
        if (cfg.sync_mode)
            pre_last = PRE_4;
        else if (cfg.wide_divisor_select && cfg.high_speed_select)
            pre_last = PRE_4;
        else if (cfg.wide_divisor_select || cfg.high_speed_select)
            pre_last = PRE_16;
        else
            pre_last = PRE_64;
    end

    // 8-bit width uses only the low byte
    assign reload   = cfg.wide_divisor_select ? cfg.divisor : {8'h00, cfg.divisor[7:0]};
    assign pre_done = (pre_reg == pre_last);
    assign count    = cnt_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            pre_reg <= '0;
        else if (restart || !run || pre_done)
            pre_reg <= '0;
        else
            pre_reg <= pre_reg + 6'h01;
    end

    // down count from reload: reload+1 prescaled periods per tick
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            cnt_reg <= '0;
        else if (restart || !run)
            cnt_reg <= reload;
        else if (pre_done)
            cnt_reg <= (cnt_reg == 16'h0000) ? reload : cnt_reg - 16'h0001;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            baud_tick <= 1'b0;
        else
            baud_tick <= run && !restart && pre_done && (cnt_reg == 16'h0000);
    end

endmodule

/* File: hdl/baud_rate_generator.sv */
// Purpose: baud rate timer of the serial port with its register file
// Assumes: 100 MHz clk stands for the oscillator clock
// Notes:   receiver state arrives on pins and is synchronised
//
// Operation
// - one dedicated timer, 8 or 16 bits, for async and sync use
// - 8-bit after reset; 16-bit only while width select set
// - timer runs only while port enable is set; period set by the reload pair
// - async multiplier chosen by high-speed and width select together
// - synchronous mode ignores the high-speed select
// - writing either reload byte restarts the timer on the next cycle
// - async, 8-bit, low speed: rate is clock / (64 (n+1))
// - async, 8-bit, high speed: rate is clock / (16 (n+1))
// - async, 16-bit, low speed: rate is clock / (16 (n+1))
// - synchronous: rate is clock / (4 (n+1))
// - low reload byte is bits 7..0, high byte bits 15..8
// - width select is bit 3 of baud control
// - high-speed select is bit 2 of transmit control
// - mode select is bit 4 of transmit control, one is sync
// - receiver idle flag is one while receiver idle
`timescale 1ns/1ps
module baud_rate_generator (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // AXI4-Lite write address
    input  wire logic [baud_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    // AXI4-Lite write data
    input  wire logic [baud_pkg::DATA_W-1:0]   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    // AXI4-Lite write response
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    // AXI4-Lite read address
    input  wire logic [baud_pkg::ADDR_W-1:0]   araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    // AXI4-Lite read data
    output logic [baud_pkg::DATA_W-1:0]        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // receiver and transmitter state
    input  wire logic                          rx_busy,
    input  wire logic                          tx_shift_empty,
    // baud output
    output logic                               baud_tick,
    output logic                               sync_mode,
    output logic                               port_enable
);
    import baud_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]        tx_ctrl_reg;
    logic [7:0]        rx_ctrl_reg;
    logic [7:0]        baud_ctl_reg;
    logic [7:0]        div_lo_reg;
    logic [7:0]        div_hi_reg;
    reg_wr_s           reg_wr;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0]        rd_data;
    logic              rd_hit;
    logic              restart_reg;
    logic [1:0]        busy_sync_reg;
    logic [1:0]        empty_sync_reg;
    baud_cfg_s         cfg;

    baud_axil_slave u_bus (
        .clk     (clk),
        .nrst    (nrst),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .reg_wr  (reg_wr),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_hit  (rd_hit)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            tx_ctrl_reg <= TX_CTRL_RST;
        else if (reg_wr.we && reg_wr.addr == OFF_TX_CTRL)
            tx_ctrl_reg <= reg_wr.data & TX_CTRL_WMASK;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rx_ctrl_reg <= RX_CTRL_RST;
        else if (reg_wr.we && reg_wr.addr == OFF_RX_CTRL)
            rx_ctrl_reg <= reg_wr.data & RX_CTRL_WMASK;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            baud_ctl_reg <= BAUD_CTL_RST;
        else if (reg_wr.we && reg_wr.addr == OFF_BAUD_CTL)
            baud_ctl_reg <= reg_wr.data & BAUD_CTL_WMASK;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_lo_reg <= DIV_RST;
            div_hi_reg <= DIV_RST;
        end else if (reg_wr.we && reg_wr.addr == OFF_DIV_LO) begin
            div_lo_reg <= reg_wr.data;
        end else if (reg_wr.we && reg_wr.addr == OFF_DIV_HI) begin
            div_hi_reg <= reg_wr.data;
        end
    end

    // a write to either reload byte restarts the timer on the next cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            restart_reg <= 1'b0;
        else
            restart_reg <= reg_wr.we && (reg_wr.addr == OFF_DIV_LO || reg_wr.addr == OFF_DIV_HI);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_sync_reg  <= 2'b00;
            empty_sync_reg <= 2'b11;
        end else begin
            busy_sync_reg  <= {busy_sync_reg[0], rx_busy};
            empty_sync_reg <= {empty_sync_reg[0], tx_shift_empty};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 8'h00;
        unique case (rd_addr)
            OFF_TX_CTRL: begin
                rd_data               = tx_ctrl_reg;
                rd_data[POS_TX_EMPTY] = empty_sync_reg[1];
            end
            OFF_RX_CTRL:  rd_data = rx_ctrl_reg;
            OFF_BAUD_CTL: begin
                rd_data              = baud_ctl_reg;
                rd_data[POS_RX_IDLE] = !busy_sync_reg[1];
            end
            OFF_DIV_LO:   rd_data = div_lo_reg;
            OFF_DIV_HI:   rd_data = div_hi_reg;
            default:      rd_hit  = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // timer

    assign cfg.sync_mode           = tx_ctrl_reg[POS_SYNC];
    assign cfg.high_speed_select   = tx_ctrl_reg[POS_HIGH_SPD];
    assign cfg.wide_divisor_select = baud_ctl_reg[POS_WIDE];
    assign cfg.divisor             = {div_hi_reg, div_lo_reg};
    assign sync_mode               = tx_ctrl_reg[POS_SYNC];
    assign port_enable             = rx_ctrl_reg[POS_PORT_EN];

    // the timer is held in reset with the serial port
    baud_timer u_timer (
        .clk       (clk),
        .nrst      (nrst),
        .cfg       (cfg),
        .restart   (restart_reg),
        .run       (rx_ctrl_reg[POS_PORT_EN]),
        .baud_tick (baud_tick),
        .count     ()
    );

endmodule

/* File: test/baud_rate_generator_sva.sv */
// Purpose: checker of the baud rate timer ports
// Assumes: bound onto baud_rate_generator
// Notes:   all properties on clk, disabled in reset
`timescale 1ns/1ps
module baud_rate_generator_sva (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        nrst,
    // bus
    input wire logic [baud_pkg::ADDR_W-1:0] awaddr,
    input wire logic                        awvalid,
    input wire logic                        awready,
    input wire logic [baud_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0]                  wstrb,
    input wire logic                        wvalid,
    input wire logic                        wready,
    input wire logic [1:0]                  bresp,
    input wire logic                        bvalid,
    input wire logic                        bready,
    input wire logic                        arvalid,
    input wire logic                        arready,
    input wire logic [baud_pkg::DATA_W-1:0] rdata,
    input wire logic                        rvalid,
    input wire logic                        rready,
    // outputs
    input wire logic                        baud_tick,
    input wire logic                        sync_mode,
    input wire logic                        port_enable
);
    import baud_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence wr_taken;
        awvalid && awready && wvalid && wready && wstrb[0];
    endsequence
    sequence tx_wr;
        wr_taken ##0 awaddr == OFF_TX_CTRL;
    endsequence
    sequence rx_wr;
        wr_taken ##0 awaddr == OFF_RX_CTRL;
    endsequence

    AST_TICK_GAP: assert property (baud_tick |=> !baud_tick [*3])
        else $error("tick too long or period below four cycles");
    AST_TICK_OFF: assert property (!port_enable && !$past(port_enable) |-> !baud_tick)
        else $error("tick while port disabled");
    AST_SYNC_BIT: assert property (tx_wr |-> ##2 sync_mode == $past(wdata[POS_SYNC], 2))
        else $error("sync mode does not follow write");
    AST_PORT_BIT: assert property (rx_wr |-> ##2 port_enable == $past(wdata[POS_PORT_EN], 2))
        else $error("port enable does not follow write");
    AST_BRESP_GO: assert property (wr_taken |-> ##[1:2] bvalid)
        else $error("write response missing");
    AST_BV_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    AST_RV_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    AST_AR_ANS: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    AST_AR_BLOCK: assert property (rvalid |-> !arready)
        else $error("address taken while read pending");
endmodule

/* File: test/baud_rate_generator_bench.sv */
// Purpose: self-checking bench of the baud rate timer
// Assumes: AXI4-Lite master tasks, 100 MHz clock
// Notes:   tick periods measured between two ticks
`timescale 1ns/1ps
module baud_rate_generator_bench;
    import baud_pkg::*;
    logic clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, rs;
    logic        awready, wready, bvalid, arready, rvalid, baud_tick, sync_mode, port_enable;
    logic        rx_busy = 0, tx_shift_empty = 1;
    logic [31:0] rd;
    int          miscompares = 0, checked = 0, p;
    logic [7:0]  txv [7] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h10, 8'h14, 8'h10};
    logic [7:0]  bcv [7] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h08};
    int          pre [7] = '{64, 16, 16, 4, 4, 4, 4};

    always #5 clk = ~clk;

    baud_rate_generator uut (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_busy(rx_busy),
        .tx_shift_empty(tx_shift_empty), .baud_tick(baud_tick), .sync_mode(sync_mode),
        .port_enable(port_enable));

    ////////////////////////////////////////////////////////////////
    task results;
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task axw(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end while (tb !== 1'b1);
    endtask

    task axr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid && arready; tr = rvalid; d = rdata; r = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end while (tr !== 1'b1);
    endtask

    task rchk(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] e);
        axr(a, rd, rs);
        chk(nm, {24'h0, e}, rd);
        chk({nm, "_resp"}, {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask

    // cycles from one tick to the next
    task meas(output int n);
        n = 0;
        do begin @(negedge clk); n++; end while (baud_tick !== 1'b1 && n < 20000);
        n = 0;
        do begin @(negedge clk); n++; end while (baud_tick !== 1'b1 && n < 20000);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rchk("tx_ctrl_rst", OFF_TX_CTRL, 8'h02);
        rchk("rx_ctrl_rst", OFF_RX_CTRL, 8'h00);
        rchk("baud_ctl_rst", OFF_BAUD_CTL, 8'h40);
        rchk("div_lo_rst", OFF_DIV_LO, 8'h00);
        rchk("div_hi_rst", OFF_DIV_HI, 8'h00);
        axr(5'h14, rd, rs);
        chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        axw(OFF_DIV_LO, 8'h55, 4'h0, rs);
        chk("no_strobe_resp", {30'h0, RESP_OKAY}, {30'h0, rs});
        rchk("no_strobe", OFF_DIV_LO, 8'h00);
        axw(5'h14, 8'h01, 4'h1, rs);
        chk("unmapped_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        axw(OFF_BAUD_CTL, 8'hFF, 4'h1, rs);
        rchk("baud_ctl_rw", OFF_BAUD_CTL, 8'h5B);
        axw(OFF_RX_CTRL, 8'h80, 4'h1, rs);
        chk("port_enable", 1, port_enable);
        axw(OFF_DIV_HI, 8'h01, 4'h1, rs);
        for (int i = 0; i < 7; i++) begin
            axw(OFF_TX_CTRL, txv[i], 4'h1, rs);
            axw(OFF_BAUD_CTL, bcv[i], 4'h1, rs);
            axw(OFF_DIV_LO, 8'h02, 4'h1, rs);
            chk("sync_mode", {31'h0, txv[i][4]}, {31'h0, sync_mode});
            meas(p);
            chk("period", pre[i] * (bcv[i][3] ? 259 : 3), p);
        end
        axw(OFF_TX_CTRL, 8'h00, 4'h1, rs);
        axw(OFF_BAUD_CTL, 8'h00, 4'h1, rs);
        axw(OFF_DIV_LO, 8'hFF, 4'h1, rs);
        repeat (200) @(posedge clk);
        axw(OFF_DIV_LO, 8'h01, 4'h1, rs);
        p = 0;
        do begin @(negedge clk); p++; end while (baud_tick !== 1'b1 && p < 20000);
        chk("restart", 1, p <= 136);
        @(posedge clk);
        rx_busy <= 1'b1;
        tx_shift_empty <= 1'b0;
        repeat (4) @(posedge clk);
        rchk("idle_busy", OFF_BAUD_CTL, 8'h00);
        rchk("tx_full", OFF_TX_CTRL, 8'h00);
        rx_busy <= 1'b0;
        repeat (4) @(posedge clk);
        rchk("idle_back", OFF_BAUD_CTL, 8'h40);
        axw(OFF_RX_CTRL, 8'h00, 4'h1, rs);
        repeat (300) @(posedge clk);
        results();
    end
endmodule

bind baud_rate_generator baud_rate_generator_sva chk (.clk(clk), .nrst(nrst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready), .baud_tick(baud_tick), .sync_mode(sync_mode),
    .port_enable(port_enable));
